// file: src/mdl_link_status.sv
// Purpose: configuration, polling and fault record of the multidrop data link
// Assumes: inputs synchronous to ref_clk; frame checker reports faults it sees
// Notes: settings take effect at power-on and at program start only
//
// Operation
// - station address 0..15; 0 makes master, 1..15 makes that slave
// - master polls slave count setting 1..15, default 7; slaves ignore it
// - master retry limit 0..10, default 3; unused on slaves
// - retries beyond the limit put the slave in communication error
// - reply timeout 5..255, default 5, in 10 ms steps
// - current scan time readable in 10 ms units
// - peak scan time kept in the same units
// - settings applied at program start or power-on only
// - slave sets master fault flag when master is in error
// - fifteen slave fault flags; code word loaded with the flag
// - link active flag follows the enabled link instruction
// - card port and built-in port link mode flags
// - own address and slave count readable copies
// - fault counts for master and each slave 1..15
// - code 01H when a polled slave does not reply in time
// - code 02H for slave breaking the address numbering
// - counter mismatch 03H seen by master, 23H by another slave
// - slave frame fault 04H; master frame fault 14H seen by slaves
// - code 11H when master sends no request after our reply
// - other slaves report 21H missing slave, 22H bad slave address
// - request before slave accepted settings gives code 31H
// - link instruction fault gives code 32H
// - exchanged block is 1 to 40 words
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mdl_link_status #(
  parameter int unsigned TICK_CYCLES = mdl_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  input wire logic runStart,
  input wire logic linkEnable,
  input wire logic portCard,
  input wire logic [5:0] blockLen,
  input wire logic rxReply,
  input wire logic rxRequest,
  input wire logic slvReplied,
  input wire mdl_pkg::mdl_fault_t linkFault,
  output logic pollReq,
  output logic [3:0] pollSlave,
  output logic masterMode
);
  // ----------------------------------------
  // settings and apply
  // ----------------------------------------
  logic [15:0] addrSet, cntSet, retrySet, timeoutSet;
  logic [3:0] ownAddr, slvCount, retryLim;
  logic [7:0] timeoutLim;
  logic powerOn, applyNow, cfgDone;
  logic linkActive, cardMode, builtinMode, linkEnD;

  assign applyNow = powerOn || runStart;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      addrSet <= mdl_pkg::RST_ADDR;
      cntSet <= mdl_pkg::RST_CNT;
      retrySet <= mdl_pkg::RST_RETRY;
      timeoutSet <= mdl_pkg::RST_TIMEOUT;
    end else if (clkEn && regWrite) begin
      unique case (regAddr)
        mdl_pkg::A_ADDR_SET: addrSet <= regWrData;
        mdl_pkg::A_CNT_SET: cntSet <= regWrData;
        mdl_pkg::A_RETRY: retrySet <= regWrData;
        mdl_pkg::A_TIMEOUT: timeoutSet <= regWrData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      powerOn <= 1'b1;
      ownAddr <= 4'h0;
      slvCount <= 4'h7;
      retryLim <= 4'h3;
      timeoutLim <= 8'h05;
      masterMode <= 1'b0;
      cfgDone <= 1'b0;
    end else if (clkEn) begin
      powerOn <= 1'b0;
      if (applyNow) begin
        ownAddr <= (addrSet > 16'(mdl_pkg::MAX_STATION)) ? mdl_pkg::MAX_STATION : addrSet[3:0];
        masterMode <= (addrSet == 16'h0000);
        slvCount <= (cntSet == 16'h0000) ? mdl_pkg::MIN_SLAVES :
                    (cntSet > 16'(mdl_pkg::MAX_STATION)) ? mdl_pkg::MAX_STATION : cntSet[3:0];
        retryLim <= (retrySet > 16'(mdl_pkg::MAX_RETRY)) ? mdl_pkg::MAX_RETRY : retrySet[3:0];
        timeoutLim <= (timeoutSet < 16'(mdl_pkg::MIN_TIMEOUT)) ? mdl_pkg::MIN_TIMEOUT :
                      (timeoutSet > 16'h00FF) ? 8'hFF : timeoutSet[7:0];
        cfgDone <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkActive <= 1'b0;
      cardMode <= 1'b0;
      builtinMode <= 1'b0;
      linkEnD <= 1'b0;
    end else if (clkEn) begin
      linkEnD <= linkEnable;
      linkActive <= linkEnable;
      cardMode <= linkEnable && portCard;
      builtinMode <= linkEnable && !portCard;
    end
  end

  // ----------------------------------------
  // 10 ms tick
  // ----------------------------------------
  logic [31:0] tickCnt;
  logic tick;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= 32'h0;
      tick <= 1'b0;
    end else if (clkEn) begin
      tick <= (tickCnt == 32'(TICK_CYCLES - 1));
      tickCnt <= (tickCnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tickCnt + 32'h1;
    end
  end

  // ----------------------------------------
  // master poll sequencer
  // ----------------------------------------
  mdl_pkg::mdl_mstate_t mState;
  logic [3:0] curSlave, retryCnt;
  logic [7:0] waitTicks;
  logic mRun, waitOver, giveUp;
  assign mRun = linkActive && masterMode;
  assign waitOver = (mState == mdl_pkg::M_WAIT) && !rxReply && tick && (waitTicks + 8'h01 >= timeoutLim);
  assign giveUp = waitOver && (retryCnt >= retryLim);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mState <= mdl_pkg::M_IDLE;
      curSlave <= 4'h1;
      retryCnt <= 4'h0;
      waitTicks <= 8'h00;
      pollReq <= 1'b0;
      pollSlave <= 4'h0;
    end else if (clkEn) begin
      pollReq <= 1'b0;
      if (!mRun || applyNow) begin
        mState <= mdl_pkg::M_IDLE;
        curSlave <= 4'h1;
        retryCnt <= 4'h0;
      end else begin
        unique case (mState)
          mdl_pkg::M_IDLE: mState <= mdl_pkg::M_POLL;
          mdl_pkg::M_POLL: begin
            pollReq <= 1'b1;
            pollSlave <= curSlave;
            waitTicks <= 8'h00;
            mState <= mdl_pkg::M_WAIT;
          end
          mdl_pkg::M_WAIT: begin
            if (rxReply || giveUp) begin
              retryCnt <= 4'h0;
              curSlave <= (curSlave >= slvCount) ? 4'h1 : curSlave + 4'h1;
              mState <= mdl_pkg::M_POLL;
            end else if (waitOver) begin
              retryCnt <= retryCnt + 4'h1;
              mState <= mdl_pkg::M_POLL;
            end else if (tick) begin
              waitTicks <= waitTicks + 8'h01;
            end
          end
          default: mState <= mdl_pkg::M_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // scan time
  // ----------------------------------------
  logic [15:0] scanRun, scanNow, scanPeak;
  logic scanMark;
  assign scanMark = masterMode ? (pollReq && pollSlave == 4'h1 && retryCnt == 4'h0) : rxRequest;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scanRun <= 16'h0;
      scanNow <= 16'h0;
      scanPeak <= 16'h0;
    end else if (clkEn) begin
      if (applyNow) begin
        scanRun <= 16'h0;
        scanNow <= 16'h0;
        scanPeak <= 16'h0;
      end else if (scanMark) begin
        scanNow <= scanRun;
        if (scanRun > scanPeak) begin
          scanPeak <= scanRun;
        end
        scanRun <= 16'h0;
      end else if (tick && scanRun != 16'hFFFF) begin
        scanRun <= scanRun + 16'h1;
      end
    end
  end

  // ----------------------------------------
  // slave watchdog on master requests
  // ----------------------------------------
  logic wdArm;
  logic [7:0] wdTicks;
  logic wdFire;
  assign wdFire = wdArm && !rxRequest && tick && (wdTicks + 8'h01 >= timeoutLim);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdArm <= 1'b0;
      wdTicks <= 8'h00;
    end else if (clkEn) begin
      if (!linkActive || masterMode || rxRequest || wdFire || applyNow) begin
        wdArm <= 1'b0;
        wdTicks <= 8'h00;
      end else if (slvReplied) begin
        wdArm <= 1'b1;
        wdTicks <= 8'h00;
      end else if (wdArm && tick) begin
        wdTicks <= wdTicks + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // fault selection
  // ----------------------------------------
  mdl_pkg::mdl_fault_t logEvt;
  logic earlyReq, badInstr;
  assign earlyReq = rxRequest && !masterMode && !(cfgDone && linkActive);
  assign badInstr = linkEnable && !linkEnD &&
                    (blockLen < mdl_pkg::MIN_BLOCK || blockLen > mdl_pkg::MAX_BLOCK);
  always_comb begin
    logEvt = '0;
    if (giveUp) begin
      logEvt = '{valid: 1'b1, station: curSlave, code: mdl_pkg::C_TIMEOUT};
    end else if (linkFault.valid) begin
      logEvt = linkFault;
    end else if (wdFire) begin
      logEvt = '{valid: 1'b1, station: 4'h0, code: mdl_pkg::C_NO_REQ};
    end else if (earlyReq) begin
      logEvt = '{valid: 1'b1, station: ownAddr, code: mdl_pkg::C_EARLY_REQ};
    end else if (badInstr) begin
      logEvt = '{valid: 1'b1, station: ownAddr, code: mdl_pkg::C_INSTR};
    end
  end

  // ----------------------------------------
  // per-station flags, counts and codes
  // ----------------------------------------
  logic [15:0] faultFlag;
  logic [15:0] faultCount [16];
  logic [7:0] faultCode [16];
  for (genvar s = 0; s < 16; s++) begin : g_st
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        faultFlag[s] <= 1'b0;
        faultCount[s] <= 16'h0;
        faultCode[s] <= 8'h00;
      end else if (clkEn) begin
        if (runStart) begin
          faultFlag[s] <= 1'b0;
        end
        if (logEvt.valid && logEvt.station == 4'(s)) begin
          faultFlag[s] <= 1'b1;
          faultCode[s] <= logEvt.code;
          if (faultCount[s] != 16'hFFFF) begin
            faultCount[s] <= faultCount[s] + 16'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 16'h0;
    end else if (clkEn) begin
      regRdData <= 16'h0;
      if (regRead) begin
        if (regAddr[7:4] == mdl_pkg::A_COUNT_BASE[7:4]) begin
          regRdData <= faultCount[regAddr[3:0]];
        end else if (regAddr[7:4] == mdl_pkg::A_CODE_BASE[7:4]) begin
          regRdData <= {8'h00, faultCode[regAddr[3:0]]};
        end else begin
          unique case (regAddr)
            mdl_pkg::A_OWN_ADDR_RB: regRdData <= {12'h0, ownAddr};
            mdl_pkg::A_SLV_CNT_RB: regRdData <= {12'h0, slvCount};
            mdl_pkg::A_RETRY: regRdData <= retrySet;
            mdl_pkg::A_TIMEOUT: regRdData <= timeoutSet;
            mdl_pkg::A_SCAN_NOW: regRdData <= scanNow;
            mdl_pkg::A_SCAN_PEAK: regRdData <= scanPeak;
            mdl_pkg::A_FLAGS: regRdData <= faultFlag;
            mdl_pkg::A_STATUS: regRdData <= {13'h0, builtinMode, cardMode, linkActive};
            default: regRdData <= 16'h0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  poll_master_only_a: assert property (pollReq |-> masterMode)
    else $error("poll issued while not master");
  poll_range_a: assert property (pollReq |-> pollSlave >= 4'h1 && pollSlave <= slvCount)
    else $error("polled slave outside configured count");
  retry_bound_a: assert property (retryCnt <= mdl_pkg::MAX_RETRY)
    else $error("retry count above ceiling");
  timeout_code_a: assert property (clkEn && giveUp && !runStart |=> faultFlag[$past(curSlave)]
    && faultCode[$past(curSlave)] == mdl_pkg::C_TIMEOUT)
    else $error("exhausted retries not recorded as timeout");
  wait_floor_a: assert property (clkEn && waitOver |-> waitTicks + 8'h01 >= mdl_pkg::MIN_TIMEOUT)
    else $error("timeout shorter than five ticks");
  peak_hold_a: assert property (scanPeak >= scanNow || $past(applyNow))
    else $error("peak scan below current scan");
  active_follow_a: assert property (clkEn |=> linkActive == $past(linkEnable))
    else $error("link active flag lags enable");
  port_excl_a: assert property (!(cardMode && builtinMode))
    else $error("both ports flagged in link mode");
  wd_code_a: assert property (clkEn && wdFire && !giveUp && !linkFault.valid |=>
    faultCode[0] == mdl_pkg::C_NO_REQ)
    else $error("missing request not recorded against master");
  early_req_a: assert property (clkEn && earlyReq && !giveUp && !linkFault.valid && !wdFire |=>
    faultCode[$past(ownAddr)] == mdl_pkg::C_EARLY_REQ)
    else $error("early request not recorded");

  poll_cycle_c: cover property (pollReq && pollSlave == slvCount ##[1:1000] pollReq && pollSlave == 4'h1);
  give_up_c: cover property (giveUp);
  wd_fire_c: cover property (wdFire);
  scan_mark_c: cover property (scanMark && scanRun != 16'h0);
endmodule
`default_nettype wire

// file: src/mdl_pkg.sv
// Purpose: shared constants and types for the multidrop link status block
// Assumes: 25 MHz reference clock, word-indexed register port
// Notes: fault codes are the link's own codes
`default_nettype none
package mdl_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [7:0] A_OWN_ADDR_RB = 8'h00;
  localparam logic [7:0] A_SLV_CNT_RB = 8'h01;
  localparam logic [7:0] A_RSVD_A = 8'h02;
  localparam logic [7:0] A_ADDR_SET = 8'h03;
  localparam logic [7:0] A_CNT_SET = 8'h04;
  localparam logic [7:0] A_RSVD_B = 8'h05;
  localparam logic [7:0] A_RETRY = 8'h06;
  localparam logic [7:0] A_TIMEOUT = 8'h07;
  localparam logic [7:0] A_SCAN_NOW = 8'h08;
  localparam logic [7:0] A_SCAN_PEAK = 8'h09;
  localparam logic [7:0] A_FLAGS = 8'h0A;
  localparam logic [7:0] A_STATUS = 8'h0B;
  localparam logic [7:0] A_COUNT_BASE = 8'h10;
  localparam logic [7:0] A_CODE_BASE = 8'h20;
  // ----------------------------------------
  // status word bits and limits
  // ----------------------------------------
  localparam int unsigned ST_ACTIVE = 0;
  localparam int unsigned ST_CARD = 1;
  localparam int unsigned ST_BUILTIN = 2;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [15:0] RST_CNT = 16'h0007;
  localparam logic [15:0] RST_RETRY = 16'h0003;
  localparam logic [15:0] RST_TIMEOUT = 16'h0005;
  localparam logic [3:0] MAX_STATION = 4'hF;
  localparam logic [3:0] MIN_SLAVES = 4'h1;
  localparam logic [3:0] MAX_RETRY = 4'hA;
  localparam logic [7:0] MIN_TIMEOUT = 8'h05;
  localparam logic [5:0] MIN_BLOCK = 6'h01;
  localparam logic [5:0] MAX_BLOCK = 6'h28;
  // ----------------------------------------
  // fault codes
  // ----------------------------------------
  localparam logic [7:0] C_TIMEOUT = 8'h01;
  localparam logic [7:0] C_NUMBER = 8'h02;
  localparam logic [7:0] C_COUNT_M = 8'h03;
  localparam logic [7:0] C_FRAME_SLV = 8'h04;
  localparam logic [7:0] C_NO_REQ = 8'h11;
  localparam logic [7:0] C_FRAME_MST = 8'h14;
  localparam logic [7:0] C_NO_SLAVE = 8'h21;
  localparam logic [7:0] C_ADDR_OTHER = 8'h22;
  localparam logic [7:0] C_COUNT_L = 8'h23;
  localparam logic [7:0] C_EARLY_REQ = 8'h31;
  localparam logic [7:0] C_INSTR = 8'h32;

  typedef struct packed {
    logic valid;
    logic [3:0] station;
    logic [7:0] code;
  } mdl_fault_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_POLL = 2'b01,
    M_WAIT = 2'b10
  } mdl_mstate_t;
endpackage
`default_nettype wire

// file: verif/mdl_slave_model.sv
// Purpose: slave stations answering the master's polls
// Assumes: one reply pulse per poll, after a set delay
// Notes: stations in the mute mask never reply
`timescale 1ns/1ps
`default_nettype none
module mdl_slave_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic pollReq,
  input wire logic [3:0] pollSlave,
  input wire logic [15:0] muteMask,
  input wire logic [7:0] replyDelay,
  output logic rxReply
);
  logic [7:0] waitCnt;
  logic pending;
  // ----------------------------------------
  // reply timing
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
      waitCnt <= 8'h00;
      rxReply <= 1'b0;
    end else begin
      rxReply <= 1'b0;
      if (pollReq && !muteMask[pollSlave]) begin
        pending <= 1'b1;
        waitCnt <= replyDelay;
      end else if (pending && waitCnt == 8'h00) begin
        pending <= 1'b0;
        rxReply <= 1'b1;
      end else if (pending) begin
        waitCnt <= waitCnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench for the link status block
// Assumes: short tick of 10 cycles
// Notes: register reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TK = 10;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdData;
  logic runStart = 1'b0;
  logic linkEnable = 1'b0;
  logic portCard = 1'b0;
  logic [5:0] blockLen = 6'h04;
  logic rxReply;
  logic rxRequest = 1'b0;
  logic slvReplied = 1'b0;
  mdl_pkg::mdl_fault_t linkFault = '0;
  logic pollReq;
  logic [3:0] pollSlave;
  logic masterMode;
  logic [15:0] muteMask = 16'h0000;
  logic [7:0] replyDelay = 8'h01;
  logic [3:0] polls[$];
  logic [7:0] codes [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h11, 8'h14, 8'h21, 8'h22, 8'h23, 8'h31, 8'h32};
  int fail_count = 0;
  int samples_checked = 0;

  always #20 ref_clk = ~ref_clk;

  mdl_link_status #(.TICK_CYCLES(TK)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .runStart(runStart),
    .linkEnable(linkEnable), .portCard(portCard), .blockLen(blockLen), .rxReply(rxReply), .rxRequest(rxRequest),
    .slvReplied(slvReplied), .linkFault(linkFault), .pollReq(pollReq), .pollSlave(pollSlave),
    .masterMode(masterMode));
  mdl_slave_model sm (.ref_clk(ref_clk), .arst_n(arst_n), .pollReq(pollReq), .pollSlave(pollSlave),
    .muteMask(muteMask), .replyDelay(replyDelay), .rxReply(rxReply));

  always @(posedge ref_clk) begin
    if (pollReq === 1'b1) polls.push_back(pollSlave);
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    v = regRdData;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] v;
    rd(a, v);
    samples_checked++;
    if ((v >= lo && v <= hi) !== 1'b1) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask
  task automatic pulse(input logic [2:0] w);
    @(posedge ref_clk);
    {slvReplied, rxRequest, runStart} <= w;
    @(posedge ref_clk);
    {slvReplied, rxRequest, runStart} <= 3'b000;
  endtask
  task automatic flt(input logic [3:0] st, input logic [7:0] c);
    @(posedge ref_clk);
    linkFault <= '{valid: 1'b1, station: st, code: c};
    @(posedge ref_clk);
    linkFault <= '0;
  endtask
  task automatic wait_n(input int n);
    int k;
    for (k = 0; k < 3000 && polls.size() < n; k++) @(posedge ref_clk);
    if (k == 3000) begin
      chk(16'(polls.size()), 16'(n));
      test_done();
    end
  endtask
  function automatic logic [3:0] sta(input int i);
    return (i == 0) ? 4'h0 : 4'(i + 3);
  endfunction
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdc(mdl_pkg::A_OWN_ADDR_RB, 16'h0000);
    rdc(mdl_pkg::A_SLV_CNT_RB, 16'h0007);
    rdc(mdl_pkg::A_RETRY, 16'h0003);
    rdc(mdl_pkg::A_TIMEOUT, 16'h0005);
    rdc(mdl_pkg::A_RSVD_A, 16'h0000);
    rdc(mdl_pkg::A_ADDR_SET, 16'h0000);
    rdc(8'h7F, 16'h0000);
    chk({15'h0000, masterMode}, 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 11; i++) flt(sta(i), codes[i]);
    for (int i = 0; i < 11; i++) begin
      rdc(mdl_pkg::A_CODE_BASE + 8'(sta(i)), {8'h00, codes[i]});
      rdc(mdl_pkg::A_COUNT_BASE + 8'(sta(i)), 16'h0001);
    end
    rdc(mdl_pkg::A_FLAGS, 16'h3FF1);
    flt(4'h4, 8'h03);
    rdc(mdl_pkg::A_COUNT_BASE + 8'h04, 16'h0002);
    rdc(mdl_pkg::A_CODE_BASE + 8'h04, 16'h0003);
    $display("test faults done");
    wr(mdl_pkg::A_CNT_SET, 16'h0003);
    wr(mdl_pkg::A_RETRY, 16'h0001);
    rdc(mdl_pkg::A_SLV_CNT_RB, 16'h0007);
    rdc(mdl_pkg::A_RETRY, 16'h0001);
    clkEn <= 1'b0;
    wr(mdl_pkg::A_RETRY, 16'h0009);
    clkEn <= 1'b1;
    rdc(mdl_pkg::A_RETRY, 16'h0001);
    pulse(3'b001);
    rdc(mdl_pkg::A_SLV_CNT_RB, 16'h0003);
    rdc(mdl_pkg::A_FLAGS, 16'h0000);
    rdc(mdl_pkg::A_CODE_BASE + 8'h04, 16'h0003);
    $display("test settings done");
    polls.delete();
    linkEnable <= 1'b1;
    rdc(mdl_pkg::A_STATUS, 16'h0005);
    wait_n(4);
    foreach (polls[i]) if (i < 4) chk({12'h000, polls[i]}, (i == 3) ? 16'h0001 : 16'(i + 1));
    linkEnable <= 1'b0;
    muteMask <= 16'h0004;
    replyDelay <= 8'h14;
    pulse(3'b001);
    polls.delete();
    linkEnable <= 1'b1;
    wait_n(4);
    foreach (polls[i]) if (i < 4) chk({12'h000, polls[i]}, (i == 0) ? 16'h0001 : 16'(i / 3 + 2));
    rdc(mdl_pkg::A_CODE_BASE + 8'h02, 16'h0001);
    rdc(mdl_pkg::A_COUNT_BASE + 8'h02, 16'h0001);
    rdc(mdl_pkg::A_FLAGS, 16'h0004);
    portCard <= 1'b1;
    rdc(mdl_pkg::A_STATUS, 16'h0003);
    $display("test polling done");
    linkEnable <= 1'b0;
    wr(mdl_pkg::A_ADDR_SET, 16'h0014);
    pulse(3'b001);
    rdc(mdl_pkg::A_OWN_ADDR_RB, 16'h000F);
    chk({15'h0000, masterMode}, 16'h0000);
    pulse(3'b010);
    rdc(mdl_pkg::A_CODE_BASE + 8'h0F, 16'h0031);
    blockLen <= 6'h29;
    @(posedge ref_clk);
    linkEnable <= 1'b1;
    rdc(mdl_pkg::A_CODE_BASE + 8'h0F, 16'h0032);
    rdc(mdl_pkg::A_COUNT_BASE + 8'h0F, 16'h0002);
    pulse(3'b010);
    repeat (30 * TK) @(posedge ref_clk);
    pulse(3'b010);
    repeat (10 * TK) @(posedge ref_clk);
    pulse(3'b010);
    rdr(mdl_pkg::A_SCAN_NOW, 16'h0009, 16'h000B);
    rdr(mdl_pkg::A_SCAN_PEAK, 16'h001D, 16'h001F);
    pulse(3'b100);
    repeat (3 * TK) @(posedge ref_clk);
    rdc(mdl_pkg::A_CODE_BASE, 16'h0001);
    repeat (5 * TK) @(posedge ref_clk);
    rdc(mdl_pkg::A_CODE_BASE, 16'h0011);
    $display("test slave done");
    test_done();
  end
endmodule
`default_nettype wire
